// ---- core/atx_core.sv ----
// atx_core: mono/stereo frame builder with slip or block-start status flag
// assumes samples arrive on the clk domain with valid/ready, pins are asynchronous,
// and an external pull-up on the open-drain interrupt line
//
// Behaviour
// - one flag, source chosen by control bit
// - source bit 0: flag reports data slip
// - source bit 1: flag reports block start
// - flag active high, sticky until status read
// - slip mode: set on every drop or repeat
// - block start: internal or external input both flag
// - mono: two consecutive samples fill A and B
// - mono under register or pin control
// - mono source channel is selectable
// - register holds mono, audio and status select
// - pins: mono enable and source select
// - source pin 0: left audio, channel A status
// - source pin 1: right audio, channel B status
// - interrupt driven low while unmasked flag set
// - status read clears flags, releases interrupt
// - mask bit disables interrupt for source
`timescale 1ns/1ps
`default_nettype none
module atx_core
   import atx_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   output var  logic [1:0]  s_axi_bresp,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire atx_pair_t   in_pair,
   input  wire logic        in_valid,
   output var  logic        in_ready,
   input  wire atx_pins_t   pins_in,
   output var  atx_frame_t  frame_o,
   output var  logic        frame_valid_o,
   output var  logic        int_n_o,
   output var  logic        int_oe_o
);

   typedef struct packed {
      logic        aw_got;                              // write address held
      logic [7:0]  awaddr;                              // held write address
      logic        w_got;                               // write data held
      logic [31:0] wdata;                               // held write data
      logic        wlane0;                              // low byte lane enabled
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic [2:0]  ctrl;                                // mono control bits
      logic        mask;                                // interrupt mask
      logic        fsel;                                // flag_source_select
      logic        flag;                                // slip_or_block_start_flag
      logic        int_oe;                              // interrupt pin drive
      logic        int_lvl;                             // level driven, always low
      atx_pins_t   s1;                                  // first synchroniser stage
      atx_pins_t   s2;                                  // second synchroniser stage
      logic        bs_prev;                             // delayed external block start
      logic [9:0]  fcnt;                                // frame timer
      logic [7:0]  fidx;                                // frame within block
      atx_seq_t    seq;                                 // sequencer state
      atx_frame_t  frm;                                 // frame being built / sent
      logic        fvalid;                              // frame strobe
   } atx_top_st_t;

   localparam atx_top_st_t RST_ST = '{seq: SQ_IDLE, ctrl: CTRL_RST, mask: MASK_RST,
                                      fsel: FSEL_RST, default: '0};

   atx_top_st_t r;                                      // current state
   atx_top_st_t n;                                      // next state
   logic        f_valid;                                // buffer head present
   logic        f_ready;                                // buffer has room
   atx_pair_t   f_data;                                 // buffer head word
   logic [4:0]  f_cnt;                                  // words buffered
   logic        pop;                                    // take head word
   logic        slip_ev;                                // sample dropped or repeated
   logic        bs_ev;                                  // block start seen
   logic        stat_rd;                                // status register read
   logic        tick;                                   // frame boundary
   logic        hw;                                     // hardware mode
   logic        eff_mono;                               // mono in force
   logic        aud_sel;                                // mono audio from right
   logic        cs_sel;                                 // mono status from channel B
   logic        ext_ev;                                 // external block start edge
   logic [3:0]  wr_hit;                                 // register hit of held write address
   logic [3:0]  rd_hit;                                 // register hit of read address

   // one-hot register hit: {state, imsk, stat, ctrl}
   function automatic logic [3:0] reg_hit(input logic [7:0] a);
      reg_hit = {a == ADDR_STATE, a == ADDR_IMSK, a == ADDR_STAT, a == ADDR_CTRL};
   endfunction

   // control source: pins in hardware mode, register bits otherwise
   assign hw       = r.s2.hw;
   assign eff_mono = hw ? r.s2.mono : r.ctrl[CTRL_MONO_BIT];
   assign aud_sel  = hw ? r.s2.src : r.ctrl[CTRL_MAUD_BIT];
   assign cs_sel   = hw ? r.s2.src : r.ctrl[CTRL_MCS_BIT];
   assign tick     = r.fcnt == FRAME_CYC - 10'h001;
   assign ext_ev   = r.s2.ext_bs && !r.bs_prev;
   assign wr_hit   = reg_hit(r.awaddr);
   assign rd_hit   = reg_hit(s_axi_araddr);

   // bus slave, frame sequencer and status flag
   always_comb begin
      n       = r;
      pop     = 1'b0;
      slip_ev = 1'b0;
      bs_ev   = 1'b0;
      stat_rd = 1'b0;
      n.fvalid = 1'b0;
      // pin synchronisers, second stage feeds logic
      n.s1      = pins_in;
      n.s2      = r.s1;
      n.bs_prev = r.s2.ext_bs;
      // write address and data, in either order
      if (s_axi_awvalid && r.awready) begin
         n.aw_got = 1'b1;
         n.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && r.wready) begin
         n.w_got  = 1'b1;
         n.wdata  = s_axi_wdata;
         n.wlane0 = s_axi_wstrb[0];
      end
      if (s_axi_bvalid && s_axi_bready) begin
         n.bvalid = 1'b0;
      end
      // both halves held: commit and answer
      if (r.aw_got && r.w_got && !r.bvalid) begin
         if (wr_hit[0] && r.wlane0) begin
            n.ctrl = r.wdata[2:0];
         end
         if (wr_hit[2] && r.wlane0) begin
            n.mask = r.wdata[IMSK_MASK_BIT];
            n.fsel = r.wdata[IMSK_FSEL_BIT];
         end
         n.bresp  = (|wr_hit) ? RESP_OKAY : RESP_SLVERR;
         n.bvalid = 1'b1;
         n.aw_got = 1'b0;
         n.w_got  = 1'b0;
      end
      // reads answer one cycle after the address is taken
      if (s_axi_rvalid && s_axi_rready) begin
         n.rvalid = 1'b0;
      end
      if (s_axi_arvalid && r.arready) begin
         unique case (rd_hit)
            4'h1: n.rdata = {29'h0, r.ctrl};
            4'h2: n.rdata = {31'h0, r.flag};
            4'h4: n.rdata = {30'h0, r.fsel, r.mask};
            4'h8: n.rdata = {25'h0, f_cnt, eff_mono, hw};
            default: n.rdata = 32'h0000_0000;
         endcase
         stat_rd  = rd_hit[1];
         n.rresp  = (|rd_hit) ? RESP_OKAY : RESP_SLVERR;
         n.rvalid = 1'b1;
      end
      n.awready = !n.aw_got && !n.bvalid;
      n.wready  = !n.w_got && !n.bvalid;
      n.arready = !n.rvalid;
      // frame timer
      n.fcnt = tick ? 10'h000 : r.fcnt + 10'h001;
      // sequencer
      unique case (r.seq)
         SQ_IDLE: begin
            if (tick) begin
               if (f_valid) begin
                  pop = 1'b1;
                  if (eff_mono) begin
                     n.frm.sub_a = aud_sel ? f_data.right : f_data.left;
                     n.frm.cs_a  = cs_sel ? f_data.cs_b : f_data.cs_a;
                  end else begin
                     n.frm.sub_a = f_data.left;
                     n.frm.sub_b = f_data.right;
                     n.frm.cs_a  = f_data.cs_a;
                     n.frm.cs_b  = f_data.cs_b;
                  end
               end else begin
                  slip_ev = 1'b1;                       // repeat
                  if (eff_mono) begin
                     n.frm.sub_a = r.frm.sub_b;
                     n.frm.cs_a  = r.frm.cs_b;
                  end
               end
               n.seq = eff_mono ? SQ_SECOND : SQ_EMIT;
            end
         end
         SQ_SECOND: begin
            // second consecutive sample of the same channel
            if (f_valid) begin
               pop = 1'b1;
               n.frm.sub_b = aud_sel ? f_data.right : f_data.left;
               n.frm.cs_b  = cs_sel ? f_data.cs_b : f_data.cs_a;
            end else begin
               slip_ev = 1'b1;                          // repeat
               n.frm.sub_b = r.frm.sub_a;
               n.frm.cs_b  = r.frm.cs_a;
            end
            n.seq = SQ_EMIT;
         end
         SQ_EMIT: begin
            n.fvalid  = 1'b1;
            n.frm.blk = r.fidx == 8'h00;
            bs_ev     = r.fidx == 8'h00;                // internal block start
            n.fidx    = (r.fidx == BLOCK_FRM - 8'h01) ? 8'h00 : r.fidx + 8'h01;
            // source still pressing on a buffer at its limit: oldest sample is dropped;
            // the take at the tick has just freed one slot, so the limit is depth-1
            if (in_valid && f_cnt >= 5'(FIFO_DEPTH - 1)) begin
               pop     = 1'b1;
               slip_ev = 1'b1;
            end
            n.seq = SQ_IDLE;
         end
         default: n.seq = SQ_IDLE;
      endcase
      // external block start realigns the block
      if (ext_ev) begin
         bs_ev  = 1'b1;
         n.fidx = 8'h00;
      end
      // sticky flag, a new event wins over the clearing read
      n.flag    = (r.fsel ? bs_ev : slip_ev) || (r.flag && !stat_rd);
      n.int_oe  = n.flag && !n.mask;
      n.int_lvl = 1'b0;
   end

   // state register
   always_ff @(posedge clk) begin
      if (rst) begin
         r <= RST_ST;
      end else begin
         r <= n;
      end
   end

   // input sample buffer
   atx_fifo #(.W($bits(atx_pair_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (in_valid),
      .in_ready  (f_ready),
      .in_data   (in_pair),
      .out_valid (f_valid),
      .out_ready (pop),
      .out_data  (f_data),
      .count     (f_cnt)
   );

   assign s_axi_awready = r.awready;
   assign s_axi_wready  = r.wready;
   assign s_axi_bvalid  = r.bvalid;
   assign s_axi_bresp   = r.bresp;
   assign s_axi_arready = r.arready;
   assign s_axi_rvalid  = r.rvalid;
   assign s_axi_rdata   = r.rdata;
   assign s_axi_rresp   = r.rresp;
   assign in_ready      = f_ready;
   assign frame_o       = r.frm;
   assign frame_valid_o = r.fvalid;
   assign int_n_o       = r.int_lvl;
   assign int_oe_o      = r.int_oe;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // mono frame: idle tick, second take, emit, strobe
   sequence s_mono_tick;
      r.seq == SQ_IDLE && tick && eff_mono;
   endsequence
   sequence s_two_takes;
      r.seq == SQ_SECOND ##1 r.seq == SQ_EMIT ##1 frame_valid_o;
   endsequence

   AST_MONO_TWO: assert property (s_mono_tick |=> s_two_takes)
      else $error("mono frame did not take two samples");
   AST_STEREO_ONE: assert property (
      r.seq == SQ_IDLE && tick && !eff_mono |=> r.seq == SQ_EMIT ##1 frame_valid_o)
      else $error("stereo frame sequence wrong");
   AST_MONO_SRC: assert property (
      s_mono_tick and f_valid |=> r.frm.sub_a == $past(aud_sel ? f_data.right : f_data.left))
      else $error("mono audio from wrong channel");
   AST_HW_PINS: assert property (
      hw && r.seq == SQ_IDLE && tick |=> (r.seq == SQ_SECOND) == $past(r.s2.mono))
      else $error("hardware mode ignores mono pin");
   AST_SW_REG: assert property (
      !hw && r.seq == SQ_IDLE && tick |=> (r.seq == SQ_SECOND) == $past(r.ctrl[CTRL_MONO_BIT]))
      else $error("software mode ignores register");
   AST_SLIP_SET: assert property (slip_ev && !r.fsel |=> r.flag)
      else $error("slip not flagged");
   AST_BS_SET: assert property ($rose(r.s2.ext_bs) && r.fsel |=> r.flag)
      else $error("external block start not flagged");
   AST_FLAG_STICKY: assert property (r.flag && !stat_rd |=> r.flag)
      else $error("flag dropped without read");
   AST_RD_CLEAR: assert property (
      stat_rd && !slip_ev && !bs_ev |=> !r.flag && !int_oe_o)
      else $error("status read did not clear");
   AST_INT_MASK: assert property (r.flag && !r.mask |-> int_oe_o && !int_n_o)
      else $error("interrupt not driven");
   AST_EMPTY_SLIP: assert property (r.seq == SQ_IDLE && tick && !f_valid |-> slip_ev)
      else $error("empty buffer not counted as slip");

endmodule
`default_nettype wire

// ---- core/atx_fifo.sv ----
// atx_fifo: valid/ready word buffer over atx_ram, head word always presented
// assumes one clock and synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module atx_fifo
   import atx_pkg::*;
#(
   parameter int W     = 50,
   parameter int DEPTH = 16
) (
   input  wire logic                       clk,
   input  wire logic                       rst,
   input  wire logic                       in_valid,
   output var  logic                       in_ready,
   input  wire logic [W-1:0]               in_data,
   output var  logic                       out_valid,
   input  wire logic                       out_ready,
   output var  logic [W-1:0]               out_data,
   output var  logic [$clog2(DEPTH):0]     count
);

   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);  // words when full

   typedef struct packed {
      logic [AW-1:0] wp;                                // write pointer
      logic [AW-1:0] rp;                                // read pointer
      logic [AW:0]   cnt;                               // words held
      logic          rdy;                               // room for a word
      logic          vld;                               // head word present
   } atx_fifo_st_t;

   atx_fifo_st_t r;                                     // current state
   atx_fifo_st_t n;                                     // next state
   logic         push;                                  // word enters
   logic         pop;                                   // word leaves

   // pointers move on handshakes; flags derive from the new count
   always_comb begin
      n    = r;
      push = in_valid && r.rdy;
      pop  = out_ready && r.vld;
      n.wp = r.wp + AW'(push);
      n.rp = r.rp + AW'(pop);
      n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
      n.rdy = n.cnt != FULL_CNT;
      n.vld = n.cnt != '0;
   end

   // state register
   always_ff @(posedge clk) begin
      if (rst) begin
         r <= '{rdy: 1'b1, default: '0};
      end else begin
         r <= n;
      end
   end

   // read address runs one step ahead so the head word is ready with the flag
   atx_ram #(.W(W), .AW(AW)) u_ram (
      .clk   (clk),
      .we    (push),
      .waddr (r.wp),
      .wdata (in_data),
      .raddr (n.rp),
      .rdata (out_data)
   );

   assign in_ready  = r.rdy;
   assign out_valid = r.vld;
   assign count     = r.cnt;

endmodule
`default_nettype wire

// ---- core/atx_pkg.sv ----
// atx_pkg: shared constants and types for the mono/slip-flag transmitter core
// assumes a single 25 MHz clock and AXI4-Lite register access with 32-bit data
package atx_pkg;

   // clock and frame timing
   localparam int         CLK_HZ    = 32'h017D_7840;     // 25 MHz core clock
   localparam int         FS_HZ     = 32'h0000_BB80;     // 48 kHz frame rate
   localparam logic [9:0] FRAME_CYC = 10'(CLK_HZ / FS_HZ); // clocks per frame, rounded down
   localparam logic [7:0] BLOCK_FRM = 8'hC0;            // frames per status block

   // register indices; byte address is four times the index
   localparam logic [5:0] REG_CTRL_IDX  = 6'h01;        // mono control
   localparam logic [5:0] REG_STAT_IDX  = 6'h04;        // sticky status
   localparam logic [5:0] REG_IMSK_IDX  = 6'h05;        // interrupt control
   localparam logic [5:0] REG_STATE_IDX = 6'h06;        // live state view
   localparam logic [7:0] ADDR_CTRL  = {REG_CTRL_IDX, 2'h0};
   localparam logic [7:0] ADDR_STAT  = {REG_STAT_IDX, 2'h0};
   localparam logic [7:0] ADDR_IMSK  = {REG_IMSK_IDX, 2'h0};
   localparam logic [7:0] ADDR_STATE = {REG_STATE_IDX, 2'h0};

   // field positions
   localparam int CTRL_MONO_BIT = 0;                    // mono enable
   localparam int CTRL_MAUD_BIT = 1;                    // mono_audio_source_select
   localparam int CTRL_MCS_BIT  = 2;                    // mono_status_source_select
   localparam int STAT_FLAG_BIT = 0;                    // slip_or_block_start_flag
   localparam int IMSK_MASK_BIT = 0;                    // mask for the flag
   localparam int IMSK_FSEL_BIT = 1;                    // flag_source_select

   // values after reset
   localparam logic [2:0] CTRL_RST = 3'h0;              // stereo, left / channel A
   localparam logic       MASK_RST = 1'h0;              // unmasked
   localparam logic       FSEL_RST = 1'h0;              // slip reporting

   // bus answers
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // input buffer shape
   localparam int FIFO_DEPTH = 16;

   // one input sample period from the audio serial port
   typedef struct packed {
      logic [23:0] left;                                // left audio word
      logic [23:0] right;                               // right audio word
      logic        cs_a;                                // channel status bit, channel A
      logic        cs_b;                                // channel status bit, channel B
   } atx_pair_t;

   // one outgoing frame toward the biphase encoder
   typedef struct packed {
      logic [23:0] sub_a;                               // subframe A audio
      logic [23:0] sub_b;                               // subframe B audio
      logic        cs_a;                                // subframe A status bit
      logic        cs_b;                                // subframe B status bit
      logic        blk;                                 // first frame of a block
   } atx_frame_t;

   // hardware-mode pins, in synchroniser order
   typedef struct packed {
      logic ext_bs;                                     // external_block_start_in
      logic src;                                        // mono_audio_source_select pin
      logic mono;                                       // mono enable pin
      logic hw;                                         // hardware mode select
   } atx_pins_t;

   // frame sequencer, one-hot
   typedef enum logic [2:0] {
      SQ_IDLE   = 3'h1,
      SQ_SECOND = 3'h2,
      SQ_EMIT   = 3'h4
   } atx_seq_t;

endpackage

// ---- core/atx_ram.sv ----
// atx_ram: small dual-port word store with registered read data
// assumes one clock; a write to the address being read is passed straight through
`timescale 1ns/1ps
`default_nettype none
module atx_ram
   import atx_pkg::*;
#(
   parameter int W  = 50,
   parameter int AW = 4
) (
   input  wire logic          clk,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [W-1:0]  wdata,
   input  wire logic [AW-1:0] raddr,
   output var  logic [W-1:0]  rdata
);

   logic [W-1:0] mem [2**AW];                           // storage, no reset needed

   // write port and registered read with write-through
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= (we && waddr == raddr) ? wdata : mem[raddr];
   end

endmodule
`default_nettype wire

// ---- verification/aes_tx_mono_and_slip_flag_tb.sv ----
// aes_tx_mono_and_slip_flag_tb: self-checking bench for atx_core
// assumes the core answers on AXI4-Lite and emits one frame per frame period
`timescale 1ns/1ps
`default_nettype none
module aes_tx_mono_and_slip_flag_tb
   import atx_pkg::*;
;
   logic clk, rst, awv, wv, bry, arv, rry, inv, awr, wr_, bv, arr, rv, inr, fv, in_n, ioe, il;
   logic [7:0]  awa, ara;
   logic [31:0] wd, rd_;
   logic [1:0]  br, rr;
   atx_pair_t   ip, p1, p2;
   atx_pins_t   pins;
   atx_frame_t  frm;
   int          err_count, check_count;
   logic [33:0] rq[$];     // expected read answers
   logic [49:0] fq[$];     // expected frames
   atx_core i_atx_core (.clk(clk), .rst(rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
      .s_axi_wready(wr_), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd_),
      .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .in_pair(ip),
      .in_valid(inv), .in_ready(inr), .pins_in(pins), .frame_o(frm),
      .frame_valid_o(fv), .int_n_o(in_n), .int_oe_o(ioe));
   atx_rx_model i_atx_rx_model (.clk(clk), .frame_valid_i(fv), .int_n_i(in_n),
      .int_oe_i(ioe), .int_line(il), .frame_cnt());
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // compare one seen value against its note
   task automatic chk(input logic [49:0] s, input logic [49:0] e);
      check_count++;
      if (s !== e) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // one write, each channel released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, tb;
      tb = 1'b0;
      @(posedge clk); awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
      while (!tb) begin
         @(negedge clk); ta = awv & awr; tw = wv & wr_; tb = bv;
         @(posedge clk); if (ta) awv <= 1'b0; if (tw) wv <= 1'b0; if (tb) bry <= 1'b0;
      end
   endtask
   // one read, answer noted for the monitor
   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      logic ta, tr;
      tr = 1'b0;
      rq.push_back(e);
      @(posedge clk); ara <= a; arv <= 1'b1; rry <= 1'b1;
      while (!tr) begin
         @(negedge clk); ta = arv & arr; tr = rv;
         @(posedge clk); if (ta) arv <= 1'b0; if (tr) rry <= 1'b0;
      end
   endtask
   task automatic wf;
      do @(negedge clk); while (fv !== 1'b1);
   endtask
   task automatic push(input atx_pair_t p);
      @(posedge clk); ip <= p; inv <= 1'b1;
      @(posedge clk); inv <= 1'b0;
   endtask
   // one frame built from fresh samples under the given controls
   task automatic fc(input logic [2:0] c, input atx_pins_t pv, input logic m, input logic s);
      wr(ADDR_CTRL, {29'h0, c}); pins <= pv; wf;
      p1 = 50'({$urandom(), $urandom()}); p2 = 50'({$urandom(), $urandom()});
      push(p1); if (m) push(p2);
      if (!m) fq.push_back({p1.left, p1.right, p1.cs_a, p1.cs_b});
      else if (!s) fq.push_back({p1.left, p2.left, p1.cs_a, p2.cs_a});
      else fq.push_back({p1.right, p2.right, p1.cs_b, p2.cs_b});
      wf;
   endtask
   // watcher: takes the oldest note whenever an answer or a frame shows
   always @(negedge clk) begin
      if (rv && rry && rq.size() > 0) chk({rr, rd_}, rq.pop_front());
      if (fv && fq.size() > 0) chk({frm.sub_a, frm.sub_b, frm.cs_a, frm.cs_b}, fq.pop_front());
   end
   initial begin
      repeat (40000) @(posedge clk);
      err_count++;
      print_verdict;
   end
   initial begin
      {awv, wv, bry, arv, rry, inv} = '0;
      {awa, ara, wd, ip, pins, err_count, check_count} = '0;
      rst = 1'b1;
      void'($urandom(32'h45BD));
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd(ADDR_CTRL, {RESP_OKAY, 29'h0, CTRL_RST});
      rd(ADDR_IMSK, {RESP_OKAY, 30'h0, FSEL_RST, MASK_RST});
      rd(8'hFC, {RESP_SLVERR, 32'h0});
      wf; chk(il, 1'b0);
      rd(ADDR_STAT, {RESP_OKAY, 32'h1});
      rd(ADDR_STAT, {RESP_OKAY, 32'h0});
      @(negedge clk); chk(il, 1'b1);
      wr(ADDR_IMSK, 32'h1); wf; chk(il, 1'b1);
      rd(ADDR_STAT, {RESP_OKAY, 32'h1});
      wr(ADDR_IMSK, 32'h2); wf;
      rd(ADDR_STAT, {RESP_OKAY, 32'h0});
      pins.ext_bs <= 1'b1; repeat (8) @(posedge clk); pins.ext_bs <= 1'b0;
      repeat (8) @(posedge clk);
      rd(ADDR_STAT, {RESP_OKAY, 32'h1});
      wr(ADDR_IMSK, 32'h0); wf;
      chk(frm.blk, 1'b1);
      fc(3'h0, 4'h0, 1'b0, 1'b0);
      fc(3'h7, 4'h0, 1'b1, 1'b1);
      fc(3'h1, 4'h0, 1'b1, 1'b0);
      fc(3'h0, 4'h7, 1'b1, 1'b1);
      fc(3'h7, 4'h3, 1'b1, 1'b0);
      fc(3'h7, 4'h1, 1'b0, 1'b0);
      @(posedge clk); ip <= 50'({$urandom(), $urandom()}); inv <= 1'b1;
      repeat (19) @(posedge clk);
      @(negedge clk); chk(inr, 1'b0);
      rd(ADDR_STAT, {RESP_OKAY, 32'h1});
      wf;
      rd(ADDR_STAT, {RESP_OKAY, 32'h1});
      inv <= 1'b0;
      rd(ADDR_STATE, {RESP_OKAY, 32'h41});
      repeat (17) wf;
      rd(ADDR_STATE, {RESP_OKAY, 32'h1});
      rd(ADDR_STAT, {RESP_OKAY, 32'h1});
      repeat (4) @(posedge clk);
      print_verdict;
   end
endmodule
`default_nettype wire

// ---- verification/atx_rx_model.sv ----
// atx_rx_model: far-side frame receiver plus the pull-up on the interrupt line
// assumes frames come as one-cycle pulses on the core clock
`timescale 1ns/1ps
`default_nettype none
module atx_rx_model
   import atx_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        frame_valid_i,
   input  wire logic        int_n_i,
   input  wire logic        int_oe_i,
   output var  logic        int_line,
   output var  logic [15:0] frame_cnt
);
   // pull-up holds the line high unless the core drives it
   assign int_line = int_oe_i ? int_n_i : 1'b1;
   // frames taken from the link
   initial frame_cnt = 16'h0;
   always @(posedge clk) begin
      if (frame_valid_i) frame_cnt <= frame_cnt + 16'h1;
   end
endmodule
`default_nettype wire
